// >>> common/dct_map.svh
`ifndef DCT_MAP_SVH
`define DCT_MAP_SVH
// Register byte addresses on the Wishbone slave.
`define DCT_A_LOW_ADDR 6'h00
`define DCT_A_HIGH_ADDR 6'h04
`define DCT_B_LOW_ADDR 6'h08
`define DCT_B_HIGH_ADDR 6'h0c
`define DCT_CONTROL_ADDR 6'h10
`define DCT_MODE_ADDR 6'h14
`define DCT_CLKSCALE_ADDR 6'h18
`define DCT_IRQ_EN_ADDR 6'h1c
`define DCT_GATE_POL_ADDR 6'h20
`define DCT_IRQ_STAT_ADDR 6'h24
`define DCT_IRQ_CLR_ADDR 6'h28
// Field positions.
`define DCT_CTL_A_RUN 4
`define DCT_CTL_A_OVF 5
`define DCT_CTL_B_RUN 6
`define DCT_CTL_B_OVF 7
`define DCT_MODE_A_LSB 0
`define DCT_MODE_A_CNT 2
`define DCT_MODE_A_GATE 3
`define DCT_MODE_B_LSB 4
`define DCT_MODE_B_CNT 6
`define DCT_MODE_B_GATE 7
`define DCT_CK_DIV_LSB 0
`define DCT_CK_A_SYS 3
`define DCT_CK_B_SYS 4
`define DCT_IE_A 1
`define DCT_IE_B 3
`define DCT_POL_A 0
`define DCT_POL_B 1
`define DCT_ST_A 0
`define DCT_ST_B 1
// Reset values.
`define DCT_RESET_BYTE 8'h00
// Prescaler divide ratios for clock_divide_select 00..11.
`define DCT_DIV0 8'd12
`define DCT_DIV1 8'd4
`define DCT_DIV2 8'd48
`define DCT_DIV3 8'd8
`endif

// >>> common/dct_pkg.sv
package dct_pkg;
  // Two-bit mode field encoding.
  typedef enum logic [1:0] {
    DCT_M13 = 2'b00,
    DCT_M16 = 2'b01,
    DCT_M8R = 2'b10,
    DCT_M3 = 2'b11
  } dct_mode_e;
  // Wishbone request from master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dct_wb_req_s;
  // Per-timer count registers.
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } dct_count_s;
endpackage : dct_pkg

// >>> hw/dct_timers.sv
// Behaviour
// - counter mode adds one per falling edge on the selected count pin.
// - each count is 16 bits, reached as separate low and high bytes.
// - 13-bit mode uses high byte and low bits 4..0; low 7..5 undefined.
// - 13-bit wrap to zero sets overflow flag and may raise interrupt.
// - count-mode bit picks external falling edges or internal clock.
// - internal clock is system clock if sysclk select set, else prescaled.
// - count only if run set and gate disabled or gate input active.
// - run bit neither clears nor loads the count; software preloads.
// - timer_b mirrors timer_a with own bits, gate and gate polarity.
// - 16-bit mode like 13-bit mode but all sixteen bits count.
// - 8-bit reload mode: low counts, wraps set flag, reload from high.
// - split mode low byte is timer_a's 8-bit counter/timer.
// - split high byte counts internal clock, timer_b run, sets b flag.
// - in split, timer_b never counts edges nor sets its flag; pulse out.
// - timer_b mode 3 stops it; in split, modes 0..2 run it.
// - overflow raises interrupt only if that timer's enable bit set.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/10ps
`include "dct_map.svh"

module dct_timers #(
  parameter int unsigned DIV_WIDTH = 8
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer_a_count_input_i,
  input wire logic timer_b_count_input_i,
  input wire logic ext_gate_a_i,
  input wire logic ext_gate_b_i,
  output logic timer_b_overflow_pulse_o,
  output logic irq_o
);

  // Elaboration check: the prescaler counter must hold the largest ratio.
  if (DIV_WIDTH < 6) begin : g_bad_div
    $error("DIV_WIDTH must be at least 6 to hold the prescale ratios.");
  end

  dct_pkg::dct_wb_req_s req;
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};

  // Software-visible state.
  dct_pkg::dct_count_s count_a;
  dct_pkg::dct_count_s count_b;
  logic [7:0] timer_control_reg;
  logic [7:0] timer_mode_reg;
  logic [7:0] clock_scale_control_reg;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] ext_irq_config_reg;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;

  // Two-flop synchronisers and a third stage for edge detection.
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [1:0] pin_last;
  logic [3:0] pin_raw;
  assign pin_raw = {ext_gate_b_i, ext_gate_a_i, timer_b_count_input_i, timer_a_count_input_i};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      // The first stage feeds only the second to keep metastability contained.
      always_ff @(posedge clock_i) begin
        if (reset_i) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // Previous synchronised count-pin level for the falling-edge detector.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pin_last <= 2'b00;
    end else begin
      pin_last <= pin_sync[1:0];
    end
  end

  wire edge_a = pin_last[0] & ~pin_sync[0];
  wire edge_b = pin_last[1] & ~pin_sync[1];

  // Prescaler produces a one-cycle tick at the selected divide ratio.
  logic [DIV_WIDTH-1:0] div_count;
  logic [DIV_WIDTH-1:0] div_limit;
  wire [1:0] div_sel = clock_scale_control_reg[`DCT_CK_DIV_LSB +: 2];
  always_comb begin
    unique case (div_sel)
      2'b00: div_limit = DIV_WIDTH'(`DCT_DIV0);
      2'b01: div_limit = DIV_WIDTH'(`DCT_DIV1);
      2'b10: div_limit = DIV_WIDTH'(`DCT_DIV2);
      2'b11: div_limit = DIV_WIDTH'(`DCT_DIV3);
    endcase
  end
  wire pre_tick = (div_count >= div_limit - DIV_WIDTH'(1));
  always_ff @(posedge clock_i) begin
    if (reset_i || pre_tick) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + DIV_WIDTH'(1);
    end
  end

  // Decoded control fields.
  dct_pkg::dct_mode_e mode_a;
  dct_pkg::dct_mode_e mode_b;
  assign mode_a = dct_pkg::dct_mode_e'(timer_mode_reg[`DCT_MODE_A_LSB +: 2]);
  assign mode_b = dct_pkg::dct_mode_e'(timer_mode_reg[`DCT_MODE_B_LSB +: 2]);
  wire run_a = timer_control_reg[`DCT_CTL_A_RUN];
  wire run_b = timer_control_reg[`DCT_CTL_B_RUN];
  wire split = (mode_a == dct_pkg::DCT_M3);

  // Internal tick per timer: system clock or prescaled tick.
  wire int_a = clock_scale_control_reg[`DCT_CK_A_SYS] | pre_tick;
  wire int_b = clock_scale_control_reg[`DCT_CK_B_SYS] | pre_tick;

  // Gate active level follows the polarity bit; a set bit means active high.
  wire gate_a_act = ~(pin_sync[2] ^ ext_irq_config_reg[`DCT_POL_A]);
  wire gate_b_act = ~(pin_sync[3] ^ ext_irq_config_reg[`DCT_POL_B]);
  wire en_a = run_a & (~timer_mode_reg[`DCT_MODE_A_GATE] | gate_a_act);
  wire en_b_norm = run_b & (~timer_mode_reg[`DCT_MODE_B_GATE] | gate_b_act);

  // Source selection; count-mode picks pin edges over internal ticks.
  wire src_a = timer_mode_reg[`DCT_MODE_A_CNT] ? edge_a : int_a;
  // In split mode timer_b ignores run and gate and never counts pin edges.
  wire src_b = (timer_mode_reg[`DCT_MODE_B_CNT] && !split) ? edge_b : int_b;
  wire step_a = en_a & src_a;
  wire step_b = (split ? 1'b1 : en_b_norm) & src_b & (mode_b != dct_pkg::DCT_M3);
  wire step_ah = split & run_b & int_a;

  // Count arithmetic per mode for one timer.
  function automatic logic [16:0] dct_next(input dct_pkg::dct_count_s c,
                                           input dct_pkg::dct_mode_e m);
    logic [12:0] s13;
    logic [16:0] r;
    s13 = {c.high, c.low[4:0]} + 13'h0001;
    r = {1'b0, c.high, c.low};
    unique case (m)
      dct_pkg::DCT_M13: begin
        r = {s13 == 13'h0000, s13[12:5], c.low[7:5], s13[4:0]};
      end
      dct_pkg::DCT_M16: begin
        r = {c.high, c.low} == 16'hffff ? 17'h10000 : {1'b0, c.high, c.low} + 17'h00001;
      end
      dct_pkg::DCT_M8R: begin
        r = c.low == 8'hff ? {1'b1, c.high, c.high} : {1'b0, c.high, c.low + 8'h01};
      end
      dct_pkg::DCT_M3: begin
        r = c.low == 8'hff ? {1'b1, c.high, 8'h00} : {1'b0, c.high, c.low + 8'h01};
      end
    endcase
    return r;
  endfunction : dct_next

  wire [16:0] res_a = dct_next(count_a, mode_a);
  wire [16:0] res_b = dct_next(count_b, mode_b);
  wire [7:0] ah_sum = count_a.high + 8'h01;
  wire ovf_a = step_a & res_a[16];
  wire ovf_ah = step_ah & (count_a.high == 8'hff);
  wire ovf_b_raw = step_b & res_b[16];
  wire set_ovf_b = split ? ovf_ah : ovf_b_raw;

  // Bus decode; a one-cycle ack per request, ack drops the cycle after.
  wire bus_req = req.cyc & req.stb & ~wb_ack_o;
  wire wr = bus_req & req.we & req.sel[0];
  wire wr_a_low = wr & (req.adr == `DCT_A_LOW_ADDR);
  wire wr_a_high = wr & (req.adr == `DCT_A_HIGH_ADDR);
  wire wr_b_low = wr & (req.adr == `DCT_B_LOW_ADDR);
  wire wr_b_high = wr & (req.adr == `DCT_B_HIGH_ADDR);
  wire wr_ctl = wr & (req.adr == `DCT_CONTROL_ADDR);
  wire wr_mode = wr & (req.adr == `DCT_MODE_ADDR);
  wire wr_ck = wr & (req.adr == `DCT_CLKSCALE_ADDR);
  wire wr_ie = wr & (req.adr == `DCT_IRQ_EN_ADDR);
  wire wr_pol = wr & (req.adr == `DCT_GATE_POL_ADDR);
  wire wr_clr = wr & (req.adr == `DCT_IRQ_CLR_ADDR);
  logic [7:0] rd_byte;
  always_comb begin
    unique case (req.adr)
      `DCT_A_LOW_ADDR: rd_byte = count_a.low;
      `DCT_A_HIGH_ADDR: rd_byte = count_a.high;
      `DCT_B_LOW_ADDR: rd_byte = count_b.low;
      `DCT_B_HIGH_ADDR: rd_byte = count_b.high;
      `DCT_CONTROL_ADDR: rd_byte = timer_control_reg;
      `DCT_MODE_ADDR: rd_byte = timer_mode_reg;
      `DCT_CLKSCALE_ADDR: rd_byte = clock_scale_control_reg;
      `DCT_IRQ_EN_ADDR: rd_byte = interrupt_enable_reg;
      `DCT_GATE_POL_ADDR: rd_byte = ext_irq_config_reg;
      `DCT_IRQ_STAT_ADDR: rd_byte = {6'h00, irq_status};
      default: rd_byte = 8'h00;
    endcase
  end

  // Bus handshake and read data register.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // Count registers; a software write wins over a count in the same cycle.
  // The run bit never touches the count, so software preloads it.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count_a <= '0;
      count_b <= '0;
    end else begin
      if (wr_a_low) count_a.low <= req.dat[7:0];
      else if (step_a) count_a.low <= res_a[7:0];
      if (wr_a_high) count_a.high <= req.dat[7:0];
      else if (step_ah) count_a.high <= ah_sum;
      else if (step_a && !split) count_a.high <= res_a[15:8];
      if (wr_b_low) count_b.low <= req.dat[7:0];
      else if (step_b) count_b.low <= res_b[7:0];
      if (wr_b_high) count_b.high <= req.dat[7:0];
      else if (step_b) count_b.high <= res_b[15:8];
    end
  end

  // Control register; hardware overflow sets win over a software clear.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      timer_control_reg <= `DCT_RESET_BYTE;
    end else begin
      timer_control_reg <= wr_ctl ? req.dat[7:0] : timer_control_reg;
      if (ovf_a) timer_control_reg[`DCT_CTL_A_OVF] <= 1'b1;
      if (set_ovf_b) timer_control_reg[`DCT_CTL_B_OVF] <= 1'b1;
    end
  end

  // Configuration registers.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      timer_mode_reg <= `DCT_RESET_BYTE;
      clock_scale_control_reg <= `DCT_RESET_BYTE;
      interrupt_enable_reg <= `DCT_RESET_BYTE;
      ext_irq_config_reg <= `DCT_RESET_BYTE;
    end else begin
      if (wr_mode) timer_mode_reg <= req.dat[7:0];
      if (wr_ck) clock_scale_control_reg <= req.dat[7:0];
      if (wr_ie) interrupt_enable_reg <= req.dat[7:0];
      if (wr_pol) ext_irq_config_reg <= req.dat[7:0];
    end
  end

  assign irq_enable = {interrupt_enable_reg[`DCT_IE_B], interrupt_enable_reg[`DCT_IE_A]};

  // Sticky status; clear register is write-one-to-clear, a new event wins.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      irq_status <= 2'b00;
    end else begin
      irq_status <= (irq_status & ~(wr_clr ? req.dat[1:0] : 2'b00)) | {set_ovf_b, ovf_a};
    end
  end

  // Interrupt and timer_b overflow pulse, both registered.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
      timer_b_overflow_pulse_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_enable);
      timer_b_overflow_pulse_o <= ovf_b_raw;
    end
  end

endmodule : dct_timers

// >>> testbench/dct_pin_model.sv
`timescale 1ns/10ps
// Outside circuit on the count and gate pins; count pins idle high.
module dct_pin_model (
  input wire logic clock_i,
  input wire logic [1:0] fire_i,
  input wire logic [1:0] gate_i,
  output logic [1:0] count_pin_o,
  output logic [1:0] gate_pin_o,
  output logic busy_o
);
  logic [2:0] phase = 3'h0;
  logic sel = 1'b0;
  // Each fire gives three clocks low, then three high, so a level never lasts under two.
  always_ff @(posedge clock_i) begin
    gate_pin_o <= gate_i;
    if (phase != 3'h0) begin
      phase <= phase - 3'h1;
    end else if (fire_i != 2'h0) begin
      phase <= 3'h6;
      sel <= fire_i[1];
    end
  end
  // The low half of the pulse goes to the selected pin only.
  assign count_pin_o = (phase > 3'h3) ? (sel ? 2'h1 : 2'h2) : 2'h3;
  assign busy_o = phase != 3'h0;
endmodule : dct_pin_model

// >>> testbench/dct_timers_chk.sv
`timescale 1ns/10ps
// Bus handshake and interrupt checks, seen from the block's ports only.
module dct_timers_chk (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic timer_b_overflow_pulse_o,
  input wire logic irq_o
);
  logic [7:0] en_q;
  wire req_open = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Shadow of the interrupt enable byte; either landing edge of a write is tolerated below.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      en_q <= 8'h00;
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 6'h1c) begin
      en_q <= wb_dat_i[7:0];
    end
  end
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_ack_follows_req: assert property (req_open |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held too long");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(req_open))
    else $error("acknowledge without request");
  a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero between answers");
  a_upper_bytes_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_unmapped_reads_zero: assert property (req_open && !wb_we_i && wb_adr_i > 6'h28 |=> wb_dat_o == 32'h0)
    else $error("unmapped read returned data");
  a_irq_needs_enable: assert property (irq_o |-> ((en_q | $past(en_q)) & 8'h0a) != 8'h00)
    else $error("interrupt raised with both enables clear");
  a_reset_quiet: assert property (disable iff (1'b0) reset_i |=> !irq_o && !wb_ack_o && !timer_b_overflow_pulse_o)
    else $error("output active after reset edge");
  c_irq_seen: cover property (irq_o);
  c_unmapped_read: cover property (req_open && !wb_we_i && wb_adr_i > 6'h28);
  c_enable_written: cover property (wb_ack_o && wb_we_i && wb_adr_i == 6'h1c);
endmodule : dct_timers_chk

bind dct_timers dct_timers_chk dct_timers_chk_inst (.clock_i(clock_i), .reset_i(reset_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timer_b_overflow_pulse_o(timer_b_overflow_pulse_o), .irq_o(irq_o));

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  dct_pkg::dct_wb_req_s bus = '0;
  logic [1:0] fire = 2'h0;
  logic [1:0] gate = 2'h0;
  logic [1:0] pins, gpins;
  logic busy, ack, ovf_pulse, irq;
  logic [31:0] rd, q;
  logic [31:0] rnd_state = 32'h00010a77;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] pulse_cnt = 8'h00;
  always #2.5 clock_i = ~clock_i;
  // Counts timer_b wrap pulses so that a scenario can see whether one came.
  always @(posedge clock_i) begin
    if (ovf_pulse === 1'b1) pulse_cnt <= pulse_cnt + 8'h01;
  end
  dct_timers dct_timers_inst (.clock_i(clock_i), .reset_i(reset_i), .wb_cyc_i(bus.cyc),
    .wb_stb_i(bus.stb), .wb_we_i(bus.we), .wb_adr_i(bus.adr), .wb_sel_i(bus.sel),
    .wb_dat_i(bus.dat), .wb_dat_o(rd), .wb_ack_o(ack), .timer_a_count_input_i(pins[0]),
    .timer_b_count_input_i(pins[1]), .ext_gate_a_i(gpins[0]), .ext_gate_b_i(gpins[1]),
    .timer_b_overflow_pulse_o(ovf_pulse), .irq_o(irq));
  dct_pin_model dct_pin_model_inst (.clock_i(clock_i), .fire_i(fire), .gate_i(gate),
    .count_pin_o(pins), .gate_pin_o(gpins), .busy_o(busy));
  function automatic logic [31:0] rnd();
    rnd_state ^= rnd_state << 13;
    rnd_state ^= rnd_state >> 17;
    rnd_state ^= rnd_state << 5;
    return rnd_state;
  endfunction : rnd
  // Count after n steps in mode m, overflow on top; low bits 7..5 of mode 0 keep their value.
  function automatic logic [16:0] expect_count(input int m, input logic [15:0] v, input int n);
    logic ovf;
    logic [12:0] c;
    ovf = 1'b0;
    repeat (n) begin
      c = {v[15:8], v[4:0]} + 13'h1;
      ovf |= (m == 1) ? v == 16'hffff : (m == 2) ? v[7:0] == 8'hff : c == 13'h0;
      if (m == 1) v = v + 16'h1;
      else if (m == 2) v[7:0] = (v[7:0] == 8'hff) ? v[15:8] : v[7:0] + 8'h1;
      else v = {c[12:5], v[7:5], c[4:0]};
    end
    return {ovf, v};
  endfunction : expect_count
  task automatic report_and_stop();
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic compare(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : compare
  // One classic cycle; the request stands until a rising edge samples ack high.
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus <= {1'b1, 1'b1, w, a, 4'h1, 24'h0, d};
    do @(posedge clock_i); while (ack !== 1'b1);
    q = rd;
    bus <= '0;
  endtask : wb
  task automatic send_edges(input int t, input int n);
    repeat (n) begin
      @(posedge clock_i);
      fire <= 2'(1 << t);
      @(posedge clock_i);
      fire <= 2'h0;
      @(posedge clock_i);
      while (busy === 1'b1) @(posedge clock_i);
    end
  endtask : send_edges
  // Watchdog: a hang counts as a mismatch and ends the run.
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    logic [15:0] v;
    logic [16:0] e;
    logic [7:0] p0;
    int n;
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    for (int a = 0; a <= 36; a += 4) begin
      wb(1'b0, 6'(a), 8'h00);
      compare("reset value", 32'h0, q);
    end
    wb(1'b0, 6'h3c, 8'h00);
    compare("unmapped read", 32'h0, q);
    wb(1'b1, 6'h1c, 8'h0a);
    // Modes 0 to 2 on both timers: a corner near the wrap, then a random start.
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 3; m++) begin
        for (int k = 0; k < 2; k++) begin
          v = k ? 16'(rnd()) : 16'hfffe;
          n = k ? int'(rnd() % 4) + 1 : 3;
          wb(1'b1, 6'h10, 8'h00);
          wb(1'b1, 6'h14, 8'((m + 4) << (4 * t)));
          wb(1'b1, 6'(8 * t), v[7:0]);
          wb(1'b1, 6'(8 * t + 4), v[15:8]);
          wb(1'b1, 6'h10, 8'(16 << (2 * t)));
          wb(1'b0, 6'(8 * t), 8'h00);
          compare("count kept by run", {24'h0, v[7:0]}, q);
          p0 = pulse_cnt;
          send_edges(t, n);
          e = expect_count(m, v, n);
          compare("overflow pulse", {31'h0, t == 1 && e[16]}, {31'h0, pulse_cnt != p0});
          wb(1'b0, 6'(8 * t), 8'h00);
          compare("count low byte", {24'h0, e[7:0]}, q);
          wb(1'b0, 6'(8 * t + 4), 8'h00);
          compare("count high byte", {24'h0, e[15:8]}, q);
          wb(1'b0, 6'h10, 8'h00);
          compare("overflow flag", {31'h0, e[16]}, {31'h0, q[5 + 2 * t]});
          compare("interrupt line", {31'h0, e[16]}, {31'h0, irq});
          wb(1'b1, 6'h28, 8'(1 << t));
          wb(1'b0, 6'h24, 8'h00);
          compare("interrupt line cleared", 32'h0, {31'h0, irq});
        end
      end
    end
    // Gate held inactive blocks edges; enables are off, so the overflow stays silent.
    wb(1'b1, 6'h10, 8'h00);
    wb(1'b1, 6'h1c, 8'h00);
    wb(1'b1, 6'h20, 8'h01);
    wb(1'b1, 6'h14, 8'h0d);
    wb(1'b1, 6'h00, 8'hff);
    wb(1'b1, 6'h04, 8'hff);
    wb(1'b1, 6'h10, 8'h10);
    send_edges(0, 2);
    wb(1'b0, 6'h00, 8'h00);
    compare("gated count", 32'hff, q);
    @(posedge clock_i);
    gate <= 2'h1;
    repeat (6) @(posedge clock_i);
    send_edges(0, 2);
    wb(1'b0, 6'h00, 8'h00);
    compare("count through gate", 32'h01, q);
    compare("masked interrupt", 32'h0, {31'h0, irq});
    // Split mode: the high byte runs on timer_b's run bit and raises timer_b's flag.
    wb(1'b1, 6'h10, 8'h00);
    wb(1'b1, 6'h18, 8'h18);
    wb(1'b1, 6'h14, 8'h03);
    wb(1'b1, 6'h04, 8'hf8);
    wb(1'b1, 6'h10, 8'h40);
    repeat (20) @(posedge clock_i);
    wb(1'b0, 6'h10, 8'h00);
    compare("split flags", 32'hc, {28'h0, q[7:4]});
    report_and_stop();
  end
endmodule : tb_top
